// *** src/fsb_data_phase_handshake.sv ***
`timescale 1ns/1ps
`include "fsb_data_defines.svh"

module tx_fifo #(
  parameter int W = `DATA_W,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic clk, // core clock
  input wire logic resetn, // sync reset, low
  input wire logic in_valid, // write request
  output logic in_ready, // room left
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // pop
  output logic [W-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("tx_fifo depth must be a power of two of at least 2");
    end
  endgenerate
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  always_comb begin
    wr_next = push ? wr_reg + AW'(1) : wr_reg;
    rd_next = pop ? rd_reg + AW'(1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!resetn)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

module fsb_data_phase_handshake (
  input wire logic CLK, // 100 MHz core clock
  input wire logic RESETN, // sync reset, low
  input wire logic BUS_CLK, // bus common clock, sampled
  input wire logic TXN_N_A_IN, // txn_n_a, low
  input wire logic DATA_VALID_N_IN, // data ready pin in
  output logic DATA_VALID_N_OUT, // data ready pin out
  output logic DATA_VALID_OE, // data ready drive enable
  input wire logic [`DATA_W-1:0] DATA_N_IN, // data pins in
  output logic [`DATA_W-1:0] DATA_N_OUT, // data pins out
  output logic DATA_OE, // data drive enable
  input wire logic [`GROUPS-1:0] GROUP_INVERT_N_IN, // inversion flags in
  output logic [`GROUPS-1:0] GROUP_INVERT_N_OUT, // inversion flags out
  input wire logic [`GROUPS-1:0] DATA_STROBE_NEG_N_IN, // neg strobes in
  output logic [`GROUPS-1:0] DATA_STROBE_NEG_N_OUT, // neg strobes out
  input wire logic [`GROUPS-1:0] DATA_STROBE_POS_N_IN, // pos strobes in
  output logic [`GROUPS-1:0] DATA_STROBE_POS_N_OUT, // pos strobes out
  output logic STROBE_OE, // strobes and flags drive enable
  input wire logic TX_VALID, // user word offered
  output logic TX_READY, // tx buffer has room
  input wire logic [`DATA_W-1:0] TX_DATA, // user word
  output logic RX_VALID, // one-cycle received word
  output fsb_data_pkg::rx_word_t RX_WORD // received word and txn_n_a mark
);
  localparam int G = `GROUPS;
  localparam int GW = `GROUP_W;

  function automatic logic need_invert(input logic [`GROUP_W-1:0] grp);
    logic [4:0] ones;
    ones = '0;
    for (int i = 0; i < GW; i++) begin
      ones = ones + 5'(grp[i]);
    end
    need_invert = ones > `GROUP_HALF;
  endfunction

  // two-stage synchronisers, then one edge-history stage for the bus and bus clock, none for txn_n_a
  fsb_data_pkg::bus_in_t bus_raw, bus_s1_reg, bus_s2_reg, bus_s3_reg;
  logic [2:0] bclk_reg;
  logic txn_n_a_s1_reg, txn_n_a_s2_reg;
  assign bus_raw = '{data: DATA_N_IN, inv: GROUP_INVERT_N_IN, valid: DATA_VALID_N_IN,
                     stb_neg: DATA_STROBE_NEG_N_IN, stb_pos: DATA_STROBE_POS_N_IN};
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      bus_s1_reg <= '1;
      bus_s2_reg <= '1;
      bus_s3_reg <= '1;
      bclk_reg <= '0;
      txn_n_a_s1_reg <= 1'b1;
      txn_n_a_s2_reg <= 1'b1;
    end else begin
      bus_s1_reg <= bus_raw;
      bus_s2_reg <= bus_s1_reg;
      bus_s3_reg <= bus_s2_reg;
      bclk_reg <= {bclk_reg[1:0], BUS_CLK};
      txn_n_a_s1_reg <= TXN_N_A_IN;
      txn_n_a_s2_reg <= txn_n_a_s1_reg;
    end
  end
  logic bclk_rise, bclk_fall;
  assign bclk_rise = bclk_reg[1] && !bclk_reg[2];
  assign bclk_fall = !bclk_reg[1] && bclk_reg[2];

  // transmit path
  logic fifo_valid, fifo_pop;
  logic [`DATA_W-1:0] fifo_data;
  fsb_data_pkg::tx_state_t tx_state_reg, tx_state_next;
  logic [`DATA_W-1:0] dout_reg, dout_next;
  logic [G-1:0] inv_reg, inv_next, sneg_reg, sneg_next, spos_reg, spos_next;
  logic valid_n_reg, valid_n_next, oe_reg, oe_next;
  logic txr_reg;

  tx_fifo #(.W(`DATA_W), .DEPTH(`TX_FIFO_DEPTH)) u_tx_fifo (
    .clk(CLK),
    .resetn(RESETN),
    .in_valid(TX_VALID && txr_reg),
    .in_ready(),
    .in_data(TX_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  // registered ready: one slot kept spare for the word accepted while it falls
  logic [5:0] fill_reg, fill_next;
  always_comb begin
    fill_next = fill_reg + 6'(TX_VALID && txr_reg) - 6'(fifo_pop);
  end
  assign fifo_pop = bclk_rise && fifo_valid;

  always_comb begin
    tx_state_next = tx_state_reg;
    dout_next = dout_reg;
    inv_next = inv_reg;
    sneg_next = sneg_reg;
    spos_next = spos_reg;
    valid_n_next = valid_n_reg;
    oe_next = oe_reg;
    if (bclk_rise) begin
      if (fifo_valid) begin
        tx_state_next = fsb_data_pkg::TX_DRIVE;
        oe_next = 1'b1;
        valid_n_next = 1'b0;
        sneg_next = '0;
        spos_next = '1;
        for (int g = 0; g < G; g++) begin
          inv_next[g] = !need_invert(fifo_data[g*GW +: GW]);
          dout_next[g*GW +: GW] = need_invert(fifo_data[g*GW +: GW]) ? fifo_data[g*GW +: GW]
                                                                      : ~fifo_data[g*GW +: GW];
        end
      end else begin
        tx_state_next = fsb_data_pkg::TX_IDLE;
        oe_next = 1'b0;
        valid_n_next = 1'b1;
        sneg_next = '1;
        spos_next = '1;
        inv_next = '1;
        dout_next = '1;
      end
    end else if (bclk_fall && tx_state_reg == fsb_data_pkg::TX_DRIVE) begin
      sneg_next = '1;
      spos_next = '0;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tx_state_reg <= fsb_data_pkg::TX_IDLE;
      dout_reg <= '1;
      inv_reg <= '1;
      sneg_reg <= '1;
      spos_reg <= '1;
      valid_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      fill_reg <= '0;
      txr_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      dout_reg <= dout_next;
      inv_reg <= inv_next;
      sneg_reg <= sneg_next;
      spos_reg <= spos_next;
      valid_n_reg <= valid_n_next;
      oe_reg <= oe_next;
      fill_reg <= fill_next;
      txr_reg <= fill_next < 6'(`TX_FIFO_DEPTH - 1);
    end
  end
  assign DATA_N_OUT = dout_reg;
  assign GROUP_INVERT_N_OUT = inv_reg;
  assign DATA_STROBE_NEG_N_OUT = sneg_reg;
  assign DATA_STROBE_POS_N_OUT = spos_reg;
  assign DATA_VALID_N_OUT = valid_n_reg;
  assign DATA_VALID_OE = oe_reg;
  assign DATA_OE = oe_reg;
  assign STROBE_OE = oe_reg;
  assign TX_READY = txr_reg;

  // receive path: groups latched on either strobe's assertion edge
  logic [`DATA_W-1:0] hold_reg, hold_next, merged;
  logic [G-1:0] stb_edge;
  logic burst_def_reg, burst_def_next, rxv_reg, rxv_next;
  fsb_data_pkg::rx_word_t rxw_reg, rxw_next;
  always_comb begin
    stb_edge = (bus_s3_reg.stb_neg & ~bus_s2_reg.stb_neg) | (bus_s3_reg.stb_pos & ~bus_s2_reg.stb_pos);
    hold_next = hold_reg;
    for (int g = 0; g < G; g++) begin
      if (stb_edge[g]) begin
        hold_next[g*GW +: GW] = bus_s2_reg.inv[g] ? ~bus_s2_reg.data[g*GW +: GW]
                                                  : bus_s2_reg.data[g*GW +: GW];
      end
    end
    merged = hold_next;
    burst_def_next = burst_def_reg;
    rxv_next = 1'b0;
    rxw_next = rxw_reg;
    if (bclk_rise && !oe_reg) begin
      if (!bus_s2_reg.valid) begin
        rxv_next = 1'b1;
        rxw_next.data = merged;
        rxw_next.deferred = burst_def_reg || !txn_n_a_s2_reg;
        burst_def_next = burst_def_reg || !txn_n_a_s2_reg;
      end else begin
        burst_def_next = !txn_n_a_s2_reg;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      hold_reg <= '0;
      burst_def_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxw_reg <= '0;
    end else begin
      hold_reg <= hold_next;
      burst_def_reg <= burst_def_next;
      rxv_reg <= rxv_next;
      rxw_reg <= rxw_next;
    end
  end
  assign RX_VALID = rxv_reg;
  assign RX_WORD = rxw_reg;

  sequence s_drive_edge;
    bclk_rise && fifo_valid;
  endsequence
  sequence s_drive_shown;
    !DATA_VALID_N_OUT && DATA_OE && DATA_STROBE_NEG_N_OUT == '0;
  endsequence
  a_valid_on_drive: assert property (@(posedge CLK) disable iff (!RESETN)
    s_drive_edge |=> s_drive_shown) else $error("data-ready not asserted with driven data");
  a_idle_clock: assert property (@(posedge CLK) disable iff (!RESETN)
    bclk_rise && !fifo_valid |=> DATA_VALID_N_OUT && !DATA_OE)
    else $error("idle clock left data-ready asserted");
  a_rx_only_valid: assert property (@(posedge CLK) disable iff (!RESETN)
    RX_VALID |-> $past(bclk_rise) && !$past(bus_s2_reg.valid) && !$past(oe_reg))
    else $error("word captured without data-ready");
  a_neg_strobe_rel: assert property (@(posedge CLK) disable iff (!RESETN)
    bclk_fall && tx_state_reg == fsb_data_pkg::TX_DRIVE |=> DATA_STROBE_NEG_N_OUT == '1)
    else $error("neg strobe not released on falling bus edge");
  a_pos_strobe_set: assert property (@(posedge CLK) disable iff (!RESETN)
    bclk_fall && tx_state_reg == fsb_data_pkg::TX_DRIVE |=> DATA_STROBE_POS_N_OUT == '0)
    else $error("pos strobe not asserted on falling bus edge");
  a_invert_group0: assert property (@(posedge CLK) disable iff (!RESETN)
    s_drive_edge |=> GROUP_INVERT_N_OUT[0] == ($countones($past(fifo_data[15:0])) <= `GROUP_HALF)
      && (GROUP_INVERT_N_OUT[0] ? ~DATA_N_OUT[15:0] : DATA_N_OUT[15:0]) == $past(fifo_data[15:0]))
    else $error("group 0 flag or pins wrong");
  a_txn_n_a_marked: assert property (@(posedge CLK) disable iff (!RESETN)
    bclk_rise && !oe_reg && !bus_s2_reg.valid && !txn_n_a_s2_reg |=> RX_VALID && RX_WORD.deferred)
    else $error("deferred transfer not marked");
  a_idle_high: assert property (@(posedge CLK) disable iff (!RESETN)
    !DATA_OE |-> DATA_VALID_N_OUT && DATA_STROBE_NEG_N_OUT == '1 && DATA_STROBE_POS_N_OUT == '1)
    else $error("undriven control not at inactive high level");
endmodule

// *** include/fsb_data_defines.svh ***
`ifndef FSB_DATA_DEFINES_SVH
`define FSB_DATA_DEFINES_SVH
`define DATA_W 64
`define GROUP_W 16
`define GROUPS 4
`define GROUP_HALF 5'h08
`define TX_FIFO_DEPTH 32
`define SYNC_STAGES 2
`endif

// *** include/fsb_data_pkg.sv ***
`include "fsb_data_defines.svh"
package fsb_data_pkg;
  typedef struct packed {
    logic deferred;
    logic [`DATA_W-1:0] data;
  } rx_word_t;
  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic [`GROUPS-1:0] inv;
    logic valid;
    logic [`GROUPS-1:0] stb_neg;
    logic [`GROUPS-1:0] stb_pos;
  } bus_in_t;
  typedef enum logic [0:0] {
    TX_IDLE,
    TX_DRIVE
  } tx_state_t;
endpackage

// *** tb/bus_agent_model.sv ***
`timescale 1ns/1ps
module bus_agent_model (
  input wire logic bus_clk, // common clock
  output logic valid_n, // data ready
  output logic txn_n_a_n, // txn_n_a
  output logic [63:0] data_n, // data pins
  output logic [3:0] inv_n, // group flags
  output logic [3:0] stb_neg_n, // neg strobes
  output logic [3:0] stb_pos_n // pos strobes
);
  initial begin
    {valid_n, txn_n_a_n, data_n, inv_n, stb_neg_n, stb_pos_n} = '1;
  end
  // changes land well after the block has sampled the rise
  task automatic send(input logic [63:0] d, input logic dfr);
    @(posedge bus_clk);
    #50;
    valid_n = 1'b0;
    txn_n_a_n = ~dfr;
    stb_pos_n = 4'hF;
    for (int g = 0; g < 4; g++) begin
      inv_n[g] = ($countones(d[16*g+:16]) <= 8);
      data_n[16*g+:16] = inv_n[g] ? ~d[16*g+:16] : d[16*g+:16];
    end
    #20 stb_neg_n = 4'h0;
    #50 stb_neg_n = 4'hF;
    stb_pos_n = 4'h0;
    // pins only valid around the strobes
    #20 {data_n, inv_n} = '1;
  endtask
  // released lines float to the pull-up level
  task automatic idle();
    @(posedge bus_clk);
    #50 {valid_n, txn_n_a_n, data_n, inv_n, stb_neg_n, stb_pos_n} = '1;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic bus_clk = 1'b0;
  logic resetn = 1'b0;
  logic tx_valid = 1'b0;
  logic [63:0] tx_data = 64'h0;
  logic tx_ready, rx_valid, vo_n, v_oe, d_oe, s_oe;
  fsb_data_pkg::rx_word_t rx_word;
  logic [63:0] d_out, w, p;
  logic [3:0] inv_out, sn_out, sp_out, f;
  logic [3:0] sn_prev = 4'hF;
  logic p_valid_n, p_txn_n_a_n;
  logic [63:0] p_data_n;
  logic [3:0] p_inv_n, p_sn_n, p_sp_n;
  int mismatches = 0;
  int check_count = 0;
  logic [63:0] exp_q[$];
  fsb_data_pkg::rx_word_t rx_q[$];
  wire vw = (v_oe ? vo_n : 1'b1) & p_valid_n;
  wire [63:0] dw = (d_oe ? d_out : {64{1'b1}}) & p_data_n;
  wire [3:0] iw = (s_oe ? inv_out : 4'hF) & p_inv_n;
  wire [3:0] nw = (s_oe ? sn_out : 4'hF) & p_sn_n;
  wire [3:0] pw = (s_oe ? sp_out : 4'hF) & p_sp_n;
  always #5 clk = ~clk;
  always #80 bus_clk = ~bus_clk;
  fsb_data_phase_handshake DUT (
    .CLK(clk), .RESETN(resetn), .BUS_CLK(bus_clk), .TXN_N_A_IN(p_txn_n_a_n),
    .DATA_VALID_N_IN(vw), .DATA_VALID_N_OUT(vo_n), .DATA_VALID_OE(v_oe),
    .DATA_N_IN(dw), .DATA_N_OUT(d_out), .DATA_OE(d_oe),
    .GROUP_INVERT_N_IN(iw), .GROUP_INVERT_N_OUT(inv_out),
    .DATA_STROBE_NEG_N_IN(nw), .DATA_STROBE_NEG_N_OUT(sn_out),
    .DATA_STROBE_POS_N_IN(pw), .DATA_STROBE_POS_N_OUT(sp_out), .STROBE_OE(s_oe),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .RX_VALID(rx_valid), .RX_WORD(rx_word)
  );
  bus_agent_model agent (
    .bus_clk(bus_clk), .valid_n(p_valid_n), .txn_n_a_n(p_txn_n_a_n), .data_n(p_data_n),
    .inv_n(p_inv_n), .stb_neg_n(p_sn_n), .stb_pos_n(p_sp_n)
  );
  task automatic check(input string what, input logic [64:0] exp, input logic [64:0] got);
    check_count++;
    if (exp !== got) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) exp_q.push_back(tx_data);
    if (rx_valid === 1'b1) rx_q.push_back(rx_word);
  end
  // each driven word starts where the neg strobes fall while driving
  always @(posedge clk) begin
    sn_prev <= sn_out;
    if (d_oe === 1'b1 && sn_prev !== 4'h0 && sn_out === 4'h0) begin
      if (exp_q.size() == 0) begin
        check("tx extra word", 65'h0, 65'h1);
      end else begin
        w = exp_q.pop_front();
        for (int g = 0; g < 4; g++) begin
          f[g] = ($countones(w[16*g+:16]) <= 8);
          p[16*g+:16] = f[g] ? ~w[16*g+:16] : w[16*g+:16];
        end
        check("tx flags", f, inv_out);
        check("tx pins", p, d_out);
        check("tx ready and pos strobes", 5'h0F, {vo_n, sp_out});
      end
    end
  end
  task automatic tx_test();
    int k;
    k = 0;
    for (int i = 0; i < 40; i++) begin
      tx_valid <= 1'b1;
      tx_data <= (k == 0) ? 64'h00FF_01FF_FFFF_0000 : {4{16'h1F00 + 16'(k)}};
      @(posedge clk);
      if (tx_ready === 1'b1) k++;
    end
    tx_valid <= 1'b0;
    check("tx buffer refuses", 65'h1, 65'(k >= 31 && k < 40));
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    check("tx all sent", 65'h0, 65'(exp_q.size()));
    check("tx released", 6'h38, {vo_n, &d_out, &sn_out, v_oe, d_oe, s_oe});
  endtask
  task automatic rx_test();
    logic [63:0] rw[3];
    rw = '{64'h00FF_01FF_FFFF_0000, 64'h8000_7FFF_0001_FFFE, 64'hFFFF_FFFF_FFFF_FFFF};
    agent.send(rw[0], 1'b0);
    agent.idle();
    agent.send(rw[1], 1'b1);
    agent.idle();
    agent.send(rw[2], 1'b0);
    agent.idle();
    repeat (40) @(posedge clk);
    check("rx word count", 65'h3, 65'(rx_q.size()));
    for (int i = 0; i < 3 && i < rx_q.size(); i++) begin
      check("rx word", {i == 1, rw[i]}, rx_q[i]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset idle", 9'h1F1, {&d_out, &inv_out, &sn_out, &sp_out, vo_n, v_oe, d_oe, s_oe, tx_ready});
    tx_test();
    rx_test();
    results();
  end
  initial begin
    #100000;
    mismatches++;
    results();
  end
endmodule
